// [verilog/tbd_top.v]
// Control logic of the three-output tunable bias converter
//
// How it works
// R1: Three outputs, each with its own 8-bit code written over the serial link.
// R2: Code maps linearly onto 0 to 30 V, about 117 mV per step.
// R3: A 4-bit boost code sets the rail between 15 V and 30 V.
// R4: Host should not program output codes below 19; device accepts any code.
// R5: Code zero connects the output to ground through the pull-down.
// R6: Shutdown switches everything off and leaves all outputs high impedance.
// R7: In active mode each output is set or switched off, codes change any time.
// R8: Power-on reset forces every register to default, device in default mode.
// R9: Host waits 5 us after digital supply rises before its first command.
// R10: Shutdown to active directly; operational flag within 300 us.
// R11: Output settling window of 35 us after select release on an update.
// R12: Five 16-bit registers, the first three write-only control registers.
// R13: Host never addresses the two test registers.
// R14: Register one sets C, register two sets A and B, register three the mode.
// R15: Data sampled on rising serial clock, command latched on select fall.
// R16: A register changes only once the full command has been latched.
`timescale 1ns/1ns
`default_nettype none
`include "tbd_regs.vh"

module tbd_top
#(
  parameter ACTIVE_CYC = `TBD_ACTIVE_CYC,
  parameter SETTLE_CYC = `TBD_SETTLE_CYC
)
(
  // Clock and power-on reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // Three-wire serial link
  input wire ser_data_i,
  input wire ser_cs_i,
  input wire ser_clk_i,
  // Converter and boost control
  output reg high_voltage_converter_on_o,
  output reg high_voltage_converter_ready_o,
  output reg [3:0] boost_rail_voltage_code_o,
  // Output codes
  output reg [7:0] high_voltage_out_a_code_o,
  output reg [7:0] high_voltage_out_b_code_o,
  output reg [7:0] high_voltage_out_c_code_o,
  // Output stage control, bit 0 = A, bit 1 = B, bit 2 = C
  output reg [2:0] out_drive_o,
  output reg [2:0] out_pulldown_o,
  output reg [2:0] out_settling_o
);

  // ==========================================================
  // Helpers
  localparam CNT_W = 17;
  localparam [CNT_W-1:0] ACTIVE_LOAD = ACTIVE_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] SETTLE_LOAD = SETTLE_CYC[CNT_W-1:0];

  // Count down to zero and stay there
  function [CNT_W-1:0] tbd_dec;
    input [CNT_W-1:0] v;
    begin
      tbd_dec = (v == {CNT_W{1'b0}}) ? v : v - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // State of one output: drive, pull-down or high impedance
  function [1:0] tbd_stage;
    input on;
    input en;
    input [7:0] code;
    begin
      if (!on || !en)
        tbd_stage = 2'b00;
      else if (code == 8'h00)
        tbd_stage = 2'b10;
      else
        tbd_stage = 2'b01;
    end
  endfunction

  // ==========================================================
  // Serial receiver
  wire [31:0] frame;
  wire [5:0] nbits;
  wire frame_vld;

  tbd_serial_rx u_rx
  (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .ser_data_i(ser_data_i),
    .ser_cs_i(ser_cs_i),
    .ser_clk_i(ser_clk_i),
    .frame_o(frame),
    .nbits_o(nbits),
    .frame_vld_o(frame_vld)
  );

  // ==========================================================
  // Frame decode
  wire hdr_short_ok;
  wire hdr_long_ok;
  wire wr_ok;
  wire [4:0] wr_addr;
  wire [15:0] wr_data;

  // Header must match the fixed, tuner and device fields for its length
  assign hdr_short_ok = (nbits == `TBD_FRAME_SHORT) &&
                        (frame[`TBD_HDR_SHORT_MSB:`TBD_HDR_LSB] == `TBD_ID_SHORT);
  assign hdr_long_ok = (nbits == `TBD_FRAME_LONG) &&
                       (frame[`TBD_HDR_LONG_MSB:`TBD_HDR_LSB] == `TBD_ID_LONG);
  assign wr_ok = frame_vld && (hdr_short_ok || hdr_long_ok); // see R16
  assign wr_addr = frame[`TBD_ADDR_MSB:`TBD_ADDR_LSB];
  assign wr_data = frame[`TBD_DATA_MSB:0];

  // ==========================================================
  // Control registers
  reg [15:0] out_c_code_r;
  reg [15:0] out_a_b_code_r;
  reg [15:0] mode_r;
  reg [15:0] test_one_r;
  reg [15:0] test_two_r;
  reg [2:0] upd_nxt;

  // Write-only registers; reset puts the device in shutdown with all codes zero
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      out_c_code_r <= {8'h00, `TBD_CODE_RST}; // see R8
      out_a_b_code_r <= {`TBD_CODE_RST, `TBD_CODE_RST}; // see R8
      mode_r <= `TBD_MODE_RST; // see R8
      test_one_r <= 16'h0000;
      test_two_r <= 16'h0000;
    end
    else if (wr_ok)
    begin
      case (wr_addr)
        `TBD_REG_OUT_C: out_c_code_r <= {8'h00, wr_data[`TBD_CODE_C_MSB:0]}; // see R14
        `TBD_REG_OUT_AB: out_a_b_code_r <= wr_data; // see R14
        `TBD_REG_MODE: mode_r <= wr_data; // see R14
        // Test registers hold their word but steer nothing in this logic
        `TBD_REG_TEST_ONE: test_one_r <= wr_data; // see R12
        `TBD_REG_TEST_TWO: test_two_r <= wr_data; // see R12
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Which outputs see an update in this cycle: bit 0 = A, bit 1 = B, bit 2 = C
  always @*
  begin
    upd_nxt = 3'b000;
    if (wr_ok && wr_addr == `TBD_REG_OUT_AB)
      upd_nxt = 3'b011;
    else if (wr_ok && wr_addr == `TBD_REG_OUT_C)
      upd_nxt = 3'b100;
  end

  // ==========================================================
  // Mode fields
  wire mode_active;
  wire [2:0] mode_en;
  wire [3:0] boost_code;
  wire [7:0] code_a;
  wire [7:0] code_b;
  wire [7:0] code_c;

  assign mode_active = mode_r[`TBD_MODE_ACTIVE_BIT];
  assign mode_en = {mode_r[`TBD_MODE_EN_C_BIT], mode_r[`TBD_MODE_EN_B_BIT], mode_r[`TBD_MODE_EN_A_BIT]};
  assign boost_code = mode_r[`TBD_MODE_BOOST_MSB:`TBD_MODE_BOOST_LSB]; // see R3
  assign code_a = out_a_b_code_r[`TBD_CODE_A_MSB:0]; // see R1
  assign code_b = out_a_b_code_r[`TBD_CODE_B_MSB:`TBD_CODE_B_LSB]; // see R1
  assign code_c = out_c_code_r[`TBD_CODE_C_MSB:0]; // see R1

  // ==========================================================
  // Activation timer
  reg [CNT_W-1:0] act_cnt_r;
  reg act_run_r;

  // Restarts on every shutdown; ready only after the full activation count
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      act_cnt_r <= {CNT_W{1'b0}};
      act_run_r <= 1'b0;
    end
    else if (!mode_active)
    begin
      act_cnt_r <= ACTIVE_LOAD; // see R10
      act_run_r <= 1'b0;
    end
    else
    begin
      act_cnt_r <= tbd_dec(act_cnt_r); // see R10
      act_run_r <= 1'b1;
    end
  end

  // ==========================================================
  // Settling timers, one per output
  reg [CNT_W-1:0] set_cnt_r [0:2];
  integer i;

  // A new write restarts the window even if the previous one is still running
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (i = 0; i < 3; i = i + 1)
        set_cnt_r[i] <= {CNT_W{1'b0}};
    end
    else
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        if (upd_nxt[i] && mode_active)
          set_cnt_r[i] <= SETTLE_LOAD; // see R11
        else if (!mode_active)
          set_cnt_r[i] <= {CNT_W{1'b0}};
        else
          set_cnt_r[i] <= tbd_dec(set_cnt_r[i]); // see R11
      end
    end
  end

  // ==========================================================
  // Output stage
  wire [1:0] stg_a;
  wire [1:0] stg_b;
  wire [1:0] stg_c;

  // Shutdown leaves every stage off, i.e. high impedance
  assign stg_a = tbd_stage(mode_active, mode_en[0], code_a); // see R5, R6, R7
  assign stg_b = tbd_stage(mode_active, mode_en[1], code_b); // see R5, R6, R7
  assign stg_c = tbd_stage(mode_active, mode_en[2], code_c); // see R5, R6, R7

  // All outputs registered; codes are passed on as they are, low codes included
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      high_voltage_converter_on_o <= 1'b0;
      high_voltage_converter_ready_o <= 1'b0;
      boost_rail_voltage_code_o <= 4'h0;
      high_voltage_out_a_code_o <= 8'h00;
      high_voltage_out_b_code_o <= 8'h00;
      high_voltage_out_c_code_o <= 8'h00;
      out_drive_o <= 3'b000;
      out_pulldown_o <= 3'b000;
      out_settling_o <= 3'b000;
    end
    else
    begin
      high_voltage_converter_on_o <= mode_active; // see R6, R10
      high_voltage_converter_ready_o <= act_run_r && (act_cnt_r == {CNT_W{1'b0}}); // see R10
      boost_rail_voltage_code_o <= boost_code; // see R3
      high_voltage_out_a_code_o <= code_a; // see R2, R4
      high_voltage_out_b_code_o <= code_b; // see R2, R4
      high_voltage_out_c_code_o <= code_c; // see R2, R4
      out_drive_o <= {stg_c[0], stg_b[0], stg_a[0]}; // see R7
      out_pulldown_o <= {stg_c[1], stg_b[1], stg_a[1]}; // see R5
      out_settling_o[0] <= (set_cnt_r[0] != {CNT_W{1'b0}}); // see R11
      out_settling_o[1] <= (set_cnt_r[1] != {CNT_W{1'b0}}); // see R11
      out_settling_o[2] <= (set_cnt_r[2] != {CNT_W{1'b0}}); // see R11
    end
  end

endmodule

`default_nettype wire

// [verilog/tbd_regs.vh]
// Register indices, field positions, reset values and timing counts for the bias converter control
`ifndef TBD_REGS_VH
`define TBD_REGS_VH

// ==========================================================
// Register indices (5-bit register field of a frame)
`define TBD_REG_OUT_C 5'h00
`define TBD_REG_OUT_AB 5'h01
`define TBD_REG_MODE 5'h10
`define TBD_REG_TEST_ONE 5'h18
`define TBD_REG_TEST_TWO 5'h12

// ==========================================================
// Frame layout
`define TBD_FRAME_SHORT 6'd30
`define TBD_FRAME_LONG 6'd32
`define TBD_HDR_SHORT_MSB 29
`define TBD_HDR_LONG_MSB 31
`define TBD_HDR_LSB 21
`define TBD_ID_SHORT 9'h0A4
`define TBD_ID_LONG 11'h6A4
`define TBD_ADDR_MSB 20
`define TBD_ADDR_LSB 16
`define TBD_DATA_MSB 15

// ==========================================================
// Data fields
`define TBD_CODE_C_MSB 7
`define TBD_CODE_A_MSB 7
`define TBD_CODE_B_MSB 15
`define TBD_CODE_B_LSB 8
`define TBD_MODE_ACTIVE_BIT 0
`define TBD_MODE_EN_A_BIT 1
`define TBD_MODE_EN_B_BIT 2
`define TBD_MODE_EN_C_BIT 3
`define TBD_MODE_BOOST_MSB 7
`define TBD_MODE_BOOST_LSB 4

// ==========================================================
// Reset values
`define TBD_CODE_RST 8'h00
`define TBD_MODE_RST 16'h0000

// ==========================================================
// Timing
`define TBD_CLK_MHZ 250
`define TBD_T_ACTIVE_US 300
`define TBD_T_SETTLE_US 35
`define TBD_ACTIVE_CYC (`TBD_T_ACTIVE_US * `TBD_CLK_MHZ)
`define TBD_SETTLE_CYC (`TBD_T_SETTLE_US * `TBD_CLK_MHZ)

`endif

// [verilog/tbd_serial_rx.v]
// Three-wire serial receiver: pin synchronisers, bit shifter and frame capture
`timescale 1ns/1ns
`default_nettype none

module tbd_serial_rx
(
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_b_i,
  // Serial pins
  input wire ser_data_i,
  input wire ser_cs_i,
  input wire ser_clk_i,
  // Captured frame
  output reg [31:0] frame_o,
  output reg [5:0] nbits_o,
  output reg frame_vld_o
);

  // ==========================================================
  // Pin synchronisers
  reg [2:0] clk_s_r;
  reg [2:0] cs_s_r;
  reg [1:0] dat_s_r;
  reg [31:0] shift_r;
  reg [5:0] cnt_r;
  wire clk_rise;
  wire cs_fall;

  // Stage 0 is read only by stage 1; edges are found between stages 1 and 2
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      clk_s_r <= 3'h0;
      cs_s_r <= 3'h0;
      dat_s_r <= 2'h0;
    end
    else
    begin
      clk_s_r <= {clk_s_r[1:0], ser_clk_i};
      cs_s_r <= {cs_s_r[1:0], ser_cs_i};
      dat_s_r <= {dat_s_r[0], ser_data_i};
    end
  end

  assign clk_rise = clk_s_r[1] & ~clk_s_r[2];
  assign cs_fall = ~cs_s_r[1] & cs_s_r[2];

  // ==========================================================
  // Shift on rising serial clock while selected, hand over on select fall
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      shift_r <= 32'h0000_0000;
      cnt_r <= 6'h00;
      frame_o <= 32'h0000_0000;
      nbits_o <= 6'h00;
      frame_vld_o <= 1'b0;
    end
    else
    begin
      frame_vld_o <= 1'b0;
      if (cs_fall)
      begin
        frame_o <= shift_r; // see R15
        nbits_o <= cnt_r;
        frame_vld_o <= 1'b1;
        cnt_r <= 6'h00;
      end
      else if (cs_s_r[1] && clk_rise)
      begin
        shift_r <= {shift_r[30:0], dat_s_r[1]}; // see R15
        // Saturate so an overlong burst is counted as invalid, not wrapped
        if (cnt_r != 6'h3F)
          cnt_r <= cnt_r + 6'h01;
      end
      else if (!cs_s_r[1])
        cnt_r <= 6'h00;
    end
  end

endmodule

`default_nettype wire

// [verification/tbd_top_assertions.sv]
// Concurrent checks on the ports of the bias converter control top
`timescale 1ns/1ns
`default_nettype none

module tbd_top_assertions
#(
  parameter int ACTIVE_CYC = 75000,
  parameter int SETTLE_CYC = 8750
)
(
  // Clock, reset and serial select
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic ser_cs_i,
  // Watched outputs
  input wire logic high_voltage_converter_on_o,
  input wire logic high_voltage_converter_ready_o,
  input wire logic [3:0] boost_rail_voltage_code_o,
  input wire logic [7:0] high_voltage_out_a_code_o,
  input wire logic [7:0] high_voltage_out_b_code_o,
  input wire logic [7:0] high_voltage_out_c_code_o,
  input wire logic [2:0] out_drive_o,
  input wire logic [2:0] out_pulldown_o,
  input wire logic [2:0] out_settling_o
);
  int rdy_cnt_r;
  int set_cnt_r;

  // ==========================================================
  // Cycle counters; long counts cannot be unrolled as repetitions
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdy_cnt_r <= 0;
      set_cnt_r <= 0;
    end
    else
    begin
      rdy_cnt_r <= high_voltage_converter_on_o ? rdy_cnt_r + 1 : 0;
      set_cnt_r <= out_settling_o[2] ? set_cnt_r + 1 : 0;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_reset_idle: assert property ($rose(rst_b_i) |-> !high_voltage_converter_on_o && out_drive_o == 3'h0
    && high_voltage_out_c_code_o == 8'h00) else $error("outputs not idle after reset");
  a_pull_zero: assert property (out_pulldown_o[0] |-> high_voltage_out_a_code_o == 8'h00)
    else $error("pull-down with nonzero code");
  a_drive_nonzero: assert property (out_drive_o[2] |-> high_voltage_out_c_code_o != 8'h00)
    else $error("drive with zero code");
  a_drive_excl: assert property ((out_drive_o & out_pulldown_o) == 3'h0)
    else $error("drive and pull-down together");
  a_shutdown_hiz: assert property (!high_voltage_converter_on_o && !$past(high_voltage_converter_on_o)
    |-> out_drive_o == 3'h0 && out_pulldown_o == 3'h0) else $error("output not high impedance");
  a_ready_time: assert property ($rose(high_voltage_converter_ready_o) |-> rdy_cnt_r >= ACTIVE_CYC - 1
    && rdy_cnt_r <= ACTIVE_CYC + 4) else $error("ready at wrong time");
  a_settle_len: assert property ($fell(out_settling_o[2]) |-> set_cnt_r >= SETTLE_CYC
    && set_cnt_r <= SETTLE_CYC + 2) else $error("settling window wrong length");
  a_frame_hold: assert property (ser_cs_i && $past(ser_cs_i, 8) |-> $stable({high_voltage_out_a_code_o,
    high_voltage_out_b_code_o, high_voltage_out_c_code_o, boost_rail_voltage_code_o}))
    else $error("register changed mid frame");
endmodule

bind tbd_top tbd_top_assertions #(.ACTIVE_CYC(ACTIVE_CYC), .SETTLE_CYC(SETTLE_CYC)) chk_u
(
  .sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i),
  .ser_cs_i(ser_cs_i),
  .high_voltage_converter_on_o(high_voltage_converter_on_o),
  .high_voltage_converter_ready_o(high_voltage_converter_ready_o),
  .boost_rail_voltage_code_o(boost_rail_voltage_code_o),
  .high_voltage_out_a_code_o(high_voltage_out_a_code_o),
  .high_voltage_out_b_code_o(high_voltage_out_b_code_o),
  .high_voltage_out_c_code_o(high_voltage_out_c_code_o),
  .out_drive_o(out_drive_o),
  .out_pulldown_o(out_pulldown_o),
  .out_settling_o(out_settling_o)
);
`default_nettype wire

// [verification/tbd_host_model.sv]
// Host side of the three-wire write link
`timescale 1ns/1ns
`default_nettype none

module tbd_host_model
(
  // Bench clock; every pin change lands on its rising edge
  input wire logic clk_i,
  // Serial pins toward the device
  output var logic ser_data_o,
  output var logic ser_cs_o,
  output var logic ser_clk_o
);
  // ==========================================================
  // Idle levels at time zero
  initial
  begin
    ser_data_o = 1'b0;
    ser_cs_o = 1'b0;
    ser_clk_o = 1'b0;
  end

  // Sends a frame MSB first; the link clock stands still outside frames
  // Half a link period is 8 bench clocks, which gives the 64 ns link clock
  task automatic send(input logic [31:0] frm, input int nbits);
    int i;
    begin
      ser_cs_o <= 1'b1;
      for (i = nbits - 1; i >= 0; i--)
      begin
        ser_data_o <= frm[i];
        repeat (8) @(posedge clk_i);
        ser_clk_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        ser_clk_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      ser_cs_o <= 1'b0;
      ser_data_o <= ~ser_data_o; // Stale data must not look valid
    end
  endtask
endmodule
`default_nettype wire

// [verification/test_tunable_bias_dac_control.sv]
// Self-checking bench for the bias converter control top
`timescale 1ns/1ns
`default_nettype none
`include "tbd_regs.vh"

module test_tunable_bias_dac_control;
  localparam int ACT = 20;
  localparam int SET = 10;
  logic sys_clk_i;
  logic rst_b_i;
  logic sd, scs, sck, on_w, rdy_w;
  logic [3:0] bst_w;
  logic [7:0] a_w, b_w, c_w;
  logic [2:0] drv_w, pd_w, set_w;
  int fails;
  int check_count;
  int cyc = 0;

  // ==========================================================
  // Clock and parts
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  tbd_host_model host_u (.clk_i(sys_clk_i), .ser_data_o(sd), .ser_cs_o(scs), .ser_clk_o(sck));
  tbd_top #(.ACTIVE_CYC(ACT), .SETTLE_CYC(SET)) dut_u
  (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ser_data_i(sd), .ser_cs_i(scs), .ser_clk_i(sck),
    .high_voltage_converter_on_o(on_w), .high_voltage_converter_ready_o(rdy_w),
    .boost_rail_voltage_code_o(bst_w), .high_voltage_out_a_code_o(a_w), .high_voltage_out_b_code_o(b_w),
    .high_voltage_out_c_code_o(c_w), .out_drive_o(drv_w), .out_pulldown_o(pd_w), .out_settling_o(set_w)
  );

  // ==========================================================
  // Shared helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] fs(input logic [4:0] r, input logic [15:0] d);
    return {2'b00, `TBD_ID_SHORT, r, d};
  endfunction
  function automatic logic [31:0] fl(input logic [4:0] r, input logic [15:0] d);
    return {`TBD_ID_LONG, r, d};
  endfunction
  // Frames start on a rising edge; the gap after each keeps select low well over 3 clocks
  task automatic wr(input logic [31:0] f, input int n);
    @(posedge sys_clk_i);
    host_u.send(f, n);
    repeat (8) @(negedge sys_clk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(negedge sys_clk_i);
    chk("on", 16'h0, on_w);
    chk("codes", 16'h0, {a_w, b_w | c_w});
    chk("pins", 16'h0, {drv_w, pd_w, set_w, bst_w});
    repeat (1250) @(posedge sys_clk_i);
    $display("do_reset done");
  endtask
  task automatic t_activate();
    int i;
    wr(fl(`TBD_REG_MODE, 16'h00AF), 32);
    chk("on", 16'h1, on_w);
    chk("boost", 16'hA, bst_w);
    chk("early ready", 16'h0, rdy_w);
    for (i = 0; i < ACT + 8 && rdy_w !== 1'b1; i++)
      @(negedge sys_clk_i);
    chk("ready", 16'h1, rdy_w);
    $display("t_activate done");
  endtask
  task automatic t_codes();
    wr(fs(`TBD_REG_OUT_AB, 16'h5A13), 30);
    chk("code ab", 16'h5A13, {b_w, a_w});
    chk("drive", 16'h3, drv_w);
    chk("pulldown", 16'h4, pd_w);
    chk("settling", 16'h3, set_w);
    repeat (SET + 4) @(negedge sys_clk_i);
    chk("settled", 16'h0, set_w);
    wr(fl(`TBD_REG_OUT_C, 16'hFF13), 32);
    chk("code c", 16'h13, c_w);
    chk("drive all", 16'h7, drv_w);
    chk("settling c", 16'h4, set_w);
    $display("t_codes done");
  endtask
  task automatic t_disable();
    wr(fs(`TBD_REG_MODE, 16'h00A3), 30);
    chk("drive a only", 16'h1, drv_w);
    chk("no pulldown", 16'h0, pd_w);
    $display("t_disable done");
  endtask
  task automatic t_refuse();
    // Unknown indices stand in for the test registers, which a host never addresses
    wr(fs(5'h02, 16'h0000), 30);
    wr(fl(5'h11, 16'h0000), 32);
    wr(fs(`TBD_REG_OUT_AB, 16'h0000), 31);
    wr({11'h6A5, `TBD_REG_OUT_C, 16'h0000}, 32);
    chk("kept ab", 16'h5A13, {b_w, a_w});
    chk("kept c", 16'h13, c_w);
    $display("t_refuse done");
  endtask
  task automatic t_shutdown();
    wr(fl(`TBD_REG_MODE, 16'h0000), 32);
    chk("off", 16'h0, on_w);
    chk("hiz", 16'h0, {drv_w, pd_w});
    wr(fs(`TBD_REG_OUT_C, 16'h0040), 30);
    chk("stored c", 16'h40, c_w);
    chk("not ready", 16'h0, rdy_w);
    chk("no settle", 16'h0, set_w);
    $display("t_shutdown done");
  endtask

  // ==========================================================
  // Hang guard, sized well above the whole sequence
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    rst_b_i = 1'b0;
    fails = 0;
    check_count = 0;
    do_reset();
    t_activate();
    t_codes();
    t_disable();
    t_refuse();
    t_shutdown();
    do_reset();
    stop_test();
  end
endmodule
`default_nettype wire
